// ### rtl/timer_unit_pkg.sv
package timer_unit_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 8;
    localparam int NUM_CNT = 7;
    localparam int IRQ_W   = 4;

    // counter slots, byte offset is slot times four
    localparam int SLOT_P12 = 0;
    localparam int SLOT_T1  = 1;
    localparam int SLOT_T2  = 2;
    localparam int SLOT_PX  = 3;
    localparam int SLOT_TX  = 4;
    localparam int SLOT_PY  = 5;
    localparam int SLOT_TY  = 6;

    localparam logic [ADDR_W-1:0] OFF_PRESCALER12 = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_TIMER1      = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_TIMER2      = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_PRESCALERX  = 6'h0c;
    localparam logic [ADDR_W-1:0] OFF_TIMERX      = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_PRESCALERY  = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_TIMERY      = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_MODE        = 6'h1c;
    localparam logic [ADDR_W-1:0] OFF_SOURCE      = 6'h20;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS  = 6'h24;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK    = 6'h28;

    // mode register fields
    localparam int MODE_X_LSB = 0;
    localparam int EDGE_X_BIT = 2;
    localparam int STOP_X_BIT = 3;
    localparam int MODE_Y_LSB = 4;
    localparam int EDGE_Y_BIT = 6;
    localparam int STOP_Y_BIT = 7;

    // count source register fields
    localparam int SRC_X_BIT  = 0;
    localparam int SRC_Y_BIT  = 1;
    localparam int SRC_12_BIT = 2;

    // interrupt status and mask fields
    localparam int IRQ_T1_BIT = 0;
    localparam int IRQ_T2_BIT = 1;
    localparam int IRQ_TX_BIT = 2;
    localparam int IRQ_TY_BIT = 3;

    localparam logic [CNT_W-1:0] LATCH_RESET  = 8'hff;
    localparam logic [CNT_W-1:0] MODE_RESET   = 8'h00;
    localparam logic [CNT_W-1:0] SOURCE_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET    = 4'h0;

    // internal count source dividers of the system clock
    localparam int SRC_DIV_SLOW = 16;
    localparam int SRC_DIV_FAST = 2;

    typedef enum logic [1:0] {
        MODE_TIMER = 2'b00,
        MODE_PULSE = 2'b01,
        MODE_EVENT = 2'b10,
        MODE_WIDTH = 2'b11
    } timer_mode_type;

endpackage

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;

    // s1 is read only by s2; a change counts once s2 and s3 agree
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a glitch seen by s2 alone never reaches the level or an edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            level_reg <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
        end
    end

    assign level = level_reg;
    assign rise  = s2_reg & s3_reg & ~level_reg;
    assign fall  = ~s2_reg & ~s3_reg & level_reg;
endmodule

// ### rtl/down_counter.sv
`timescale 1ns/1ps
module down_counter #(
    parameter int               WIDTH       = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             tick,
    input  wire logic             run,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic      [WIDTH-1:0] count,
    output logic                  underflow
);
    logic [WIDTH-1:0] latch_reg;
    logic [WIDTH-1:0] count_reg;
    logic             started_reg;
    logic             underflow_reg;
    logic             direct_load;

    if (WIDTH < 2) begin : g_width_check
        $error("down_counter width too small");
    end

    assign direct_load = load & (~run | ~started_reg);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            latch_reg <= RESET_VALUE;
        end else if (load) begin
            latch_reg <= load_value;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            started_reg <= 1'b0;
        end else if (tick && run) begin
            started_reg <= 1'b1;
        end
    end

    // divide by latch plus one: n, n-1 .. 0, then reload
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= RESET_VALUE;
        end else if (direct_load) begin
            count_reg <= load_value;
        end else if (tick && run) begin
            if (count_reg == '0) begin
                count_reg <= latch_reg;
            end else begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            underflow_reg <= 1'b0;
        end else begin
            underflow_reg <= tick & run & ~direct_load & (count_reg == '0);
        end
    end

    assign count     = count_reg;
    assign underflow = underflow_reg;
endmodule

// ### rtl/four_timer_unit.sv
`timescale 1ns/1ps
// Behaviour
// - every timer and prescaler divides its input by latch value plus one
// - counters count down, reload from latch after zero, keep running
// - each timer underflow sets that timer's interrupt request bit
// - shared prescaler source is selectable; its output clocks timers 1 and 2
// - timers x and y have four modes; timer mode counts internal source
// - pulse output mode toggles the counter pin at each zero
// - pulse output starts high for edge bit zero, low for one
// - event counter mode counts counter pin pulses instead of internal source
// - event counter counts rising edges for edge bit zero, falling for one
// - width mode counts only while pin high (edge zero) or low (one)
// - count stop bit halts timer x or y in any mode
module four_timer_unit
    import timer_unit_pkg::*;
#(
    parameter int SLOW_DIV = SRC_DIV_SLOW,
    parameter int FAST_DIV = SRC_DIV_FAST
) (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [DATA_W-1:0] writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [DATA_W-1:0] readdata,
    output logic                   waitrequest,
    input  wire logic              timer_x_counter_pin_in,
    output logic                   timer_x_counter_pin_out,
    output logic                   timer_x_counter_pin_oe,
    input  wire logic              timer_y_counter_pin_in,
    output logic                   timer_y_counter_pin_out,
    output logic                   timer_y_counter_pin_oe,
    output logic                   irq
);
    localparam int SLOW_W = $clog2(SLOW_DIV);
    localparam int FAST_W = $clog2(FAST_DIV);

    if (SLOW_DIV < 2 || FAST_DIV < 2) begin : g_div_check
        $error("source dividers must be two or more");
    end

    if (NUM_CNT > (1 << (ADDR_W - 2))) begin : g_slot_check
        $error("counter slots exceed the word address range");
    end

    // bus slave signals
    logic              ack_reg;
    logic              wr_fire;
    logic              low_lane;
    logic [DATA_W-1:0] readdata_reg;
    logic [DATA_W-1:0] read_mux;
    logic [3:0]        word_index;

    // configuration and status
    logic [CNT_W-1:0] mode_reg;
    logic [CNT_W-1:0] source_reg;
    logic [IRQ_W-1:0] status_reg;
    logic [IRQ_W-1:0] status_next;
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] irq_events;
    logic             irq_reg;

    // internal count sources
    logic [SLOW_W-1:0] slow_cnt_reg;
    logic [FAST_W-1:0] fast_cnt_reg;
    logic              slow_tick_reg;
    logic              fast_tick_reg;

    // counter array
    logic [NUM_CNT-1:0] cnt_tick;
    logic [NUM_CNT-1:0] cnt_run;
    logic [NUM_CNT-1:0] cnt_load;
    logic [NUM_CNT-1:0] cnt_underflow;
    logic [CNT_W-1:0]   cnt_value [NUM_CNT];

    // counter pins
    logic           x_level;
    logic           x_rise;
    logic           x_fall;
    logic           y_level;
    logic           y_rise;
    logic           y_fall;
    timer_mode_type x_mode;
    timer_mode_type y_mode;
    logic           x_edge_sel;
    logic           y_edge_sel;
    logic           x_stop;
    logic           y_stop;
    logic           x_tick;
    logic           y_tick;
    logic           x_pulse_reg;
    logic           y_pulse_reg;
    logic           x_oe_reg;
    logic           y_oe_reg;

    // one wait state: request taken on the first edge, completed on the second
    assign waitrequest = (read | write) & ~ack_reg;
    assign wr_fire     = write & ack_reg;
    assign low_lane    = byteenable[0];
    assign word_index  = address[ADDR_W-1:2];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read | write) & ~ack_reg;
        end
    end

    // counter slots read the live count, not the latch
    always_comb begin
        read_mux = '0;
        case (address)
            OFF_PRESCALER12: read_mux[CNT_W-1:0] = cnt_value[SLOT_P12];
            OFF_TIMER1:      read_mux[CNT_W-1:0] = cnt_value[SLOT_T1];
            OFF_TIMER2:      read_mux[CNT_W-1:0] = cnt_value[SLOT_T2];
            OFF_PRESCALERX:  read_mux[CNT_W-1:0] = cnt_value[SLOT_PX];
            OFF_TIMERX:      read_mux[CNT_W-1:0] = cnt_value[SLOT_TX];
            OFF_PRESCALERY:  read_mux[CNT_W-1:0] = cnt_value[SLOT_PY];
            OFF_TIMERY:      read_mux[CNT_W-1:0] = cnt_value[SLOT_TY];
            OFF_MODE:        read_mux[CNT_W-1:0] = mode_reg;
            OFF_SOURCE:      read_mux[CNT_W-1:0] = source_reg;
            OFF_IRQ_STATUS:  read_mux[IRQ_W-1:0] = status_reg;
            OFF_IRQ_MASK:    read_mux[IRQ_W-1:0] = mask_reg;
            default:         read_mux = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            readdata_reg <= '0;
        end else if (read && !ack_reg) begin
            readdata_reg <= read_mux;
        end
    end

    assign readdata = readdata_reg;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= MODE_RESET;
        end else if (wr_fire && low_lane && address == OFF_MODE) begin
            mode_reg <= writedata[CNT_W-1:0];
        end
    end

    // source change mid-count can glitch a count; software orders it first
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            source_reg <= SOURCE_RESET;
        end else if (wr_fire && low_lane && address == OFF_SOURCE) begin
            source_reg <= writedata[CNT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mask_reg <= IRQ_RESET;
        end else if (wr_fire && low_lane && address == OFF_IRQ_MASK) begin
            mask_reg <= writedata[IRQ_W-1:0];
        end
    end

    // internal count source enables
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            slow_cnt_reg  <= '0;
            slow_tick_reg <= 1'b0;
        end else if (slow_cnt_reg == SLOW_W'(SLOW_DIV - 1)) begin
            slow_cnt_reg  <= '0;
            slow_tick_reg <= 1'b1;
        end else begin
            slow_cnt_reg  <= slow_cnt_reg + 1'b1;
            slow_tick_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fast_cnt_reg  <= '0;
            fast_tick_reg <= 1'b0;
        end else if (fast_cnt_reg == FAST_W'(FAST_DIV - 1)) begin
            fast_cnt_reg  <= '0;
            fast_tick_reg <= 1'b1;
        end else begin
            fast_cnt_reg  <= fast_cnt_reg + 1'b1;
            fast_tick_reg <= 1'b0;
        end
    end

    // counter pin front ends
    pin_sync u_sync_x (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .pin     (timer_x_counter_pin_in),
        .level   (x_level),
        .rise    (x_rise),
        .fall    (x_fall)
    );

    pin_sync u_sync_y (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .pin     (timer_y_counter_pin_in),
        .level   (y_level),
        .rise    (y_rise),
        .fall    (y_fall)
    );

    assign x_mode     = timer_mode_type'(mode_reg[MODE_X_LSB +: 2]);
    assign y_mode     = timer_mode_type'(mode_reg[MODE_Y_LSB +: 2]);
    assign x_edge_sel = mode_reg[EDGE_X_BIT];
    assign y_edge_sel = mode_reg[EDGE_Y_BIT];
    assign x_stop     = mode_reg[STOP_X_BIT];
    assign y_stop     = mode_reg[STOP_Y_BIT];

    always_comb begin
        case (x_mode)
            MODE_TIMER: x_tick = cnt_underflow[SLOT_PX];
            MODE_PULSE: x_tick = cnt_underflow[SLOT_PX];
            MODE_EVENT: x_tick = x_edge_sel ? x_fall : x_rise;
            MODE_WIDTH: x_tick = cnt_underflow[SLOT_PX] & (x_level ^ x_edge_sel);
            default:    x_tick = 1'b0;
        endcase
    end

    always_comb begin
        case (y_mode)
            MODE_TIMER: y_tick = cnt_underflow[SLOT_PY];
            MODE_PULSE: y_tick = cnt_underflow[SLOT_PY];
            MODE_EVENT: y_tick = y_edge_sel ? y_fall : y_rise;
            MODE_WIDTH: y_tick = cnt_underflow[SLOT_PY] & (y_level ^ y_edge_sel);
            default:    y_tick = 1'b0;
        endcase
    end

    // tick and run per slot
    always_comb begin
        cnt_tick          = '0;
        cnt_run           = '1;
        cnt_tick[SLOT_P12] = source_reg[SRC_12_BIT] ? slow_tick_reg : fast_tick_reg;
        cnt_tick[SLOT_T1] = cnt_underflow[SLOT_P12];
        cnt_tick[SLOT_T2] = cnt_underflow[SLOT_P12];
        cnt_tick[SLOT_PX] = source_reg[SRC_X_BIT] ? slow_tick_reg : fast_tick_reg;
        cnt_tick[SLOT_TX] = x_tick;
        cnt_tick[SLOT_PY] = source_reg[SRC_Y_BIT] ? slow_tick_reg : fast_tick_reg;
        cnt_tick[SLOT_TY] = y_tick;
        cnt_run[SLOT_TX]  = ~x_stop;
        cnt_run[SLOT_TY]  = ~y_stop;
    end

    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        assign cnt_load[i] = wr_fire & low_lane & (word_index == 4'(i));

        down_counter #(
            .WIDTH       (CNT_W),
            .RESET_VALUE (LATCH_RESET)
        ) u_cnt (
            .sys_clk    (sys_clk),
            .resetn     (resetn),
            .tick       (cnt_tick[i]),
            .run        (cnt_run[i]),
            .load       (cnt_load[i]),
            .load_value (writedata[CNT_W-1:0]),
            .count      (cnt_value[i]),
            .underflow  (cnt_underflow[i])
        );
    end

    // pulse output: start level held until the mode is entered
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            x_pulse_reg <= 1'b1;
        end else if (x_mode != MODE_PULSE) begin
            x_pulse_reg <= ~x_edge_sel;
        end else if (cnt_underflow[SLOT_TX]) begin
            x_pulse_reg <= ~x_pulse_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            y_pulse_reg <= 1'b1;
        end else if (y_mode != MODE_PULSE) begin
            y_pulse_reg <= ~y_edge_sel;
        end else if (cnt_underflow[SLOT_TY]) begin
            y_pulse_reg <= ~y_pulse_reg;
        end
    end

    // oe mirrors the mode field from its own flop, updated on the mode write
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            x_oe_reg <= 1'b0;
            y_oe_reg <= 1'b0;
        end else if (wr_fire && low_lane && address == OFF_MODE) begin
            x_oe_reg <= (writedata[MODE_X_LSB +: 2] == MODE_PULSE);
            y_oe_reg <= (writedata[MODE_Y_LSB +: 2] == MODE_PULSE);
        end
    end

    // the port direction outside still has to be set by software
    assign timer_x_counter_pin_out = x_pulse_reg;
    assign timer_x_counter_pin_oe  = x_oe_reg;
    assign timer_y_counter_pin_out = y_pulse_reg;
    assign timer_y_counter_pin_oe  = y_oe_reg;

    // interrupt requests: set wins over a write-one clear
    always_comb begin
        irq_events             = '0;
        irq_events[IRQ_T1_BIT] = cnt_underflow[SLOT_T1];
        irq_events[IRQ_T2_BIT] = cnt_underflow[SLOT_T2];
        irq_events[IRQ_TX_BIT] = cnt_underflow[SLOT_TX];
        irq_events[IRQ_TY_BIT] = cnt_underflow[SLOT_TY];
        status_next = status_reg;
        if (wr_fire && low_lane && address == OFF_IRQ_STATUS) begin
            status_next = status_reg & ~writedata[IRQ_W-1:0];
        end
        status_next = status_next | irq_events;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= IRQ_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // registered: costs one cycle, keeps the level free of decode glitches
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    assign irq = irq_reg;
endmodule

// ### bench/four_timer_unit_props.sv
`timescale 1ns/1ps
module four_timer_unit_props
    import timer_unit_pkg::*;
#(
    parameter int SLOW_DIV = SRC_DIV_SLOW,
    parameter int FAST_DIV = SRC_DIV_FAST
) (
    input wire logic              sys_clk,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic              read,
    input wire logic              write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [3:0]        byteenable,
    input wire logic [DATA_W-1:0] readdata,
    input wire logic              waitrequest,
    input wire logic              timer_x_counter_pin_in,
    input wire logic              timer_x_counter_pin_out,
    input wire logic              timer_x_counter_pin_oe,
    input wire logic              timer_y_counter_pin_in,
    input wire logic              timer_y_counter_pin_out,
    input wire logic              timer_y_counter_pin_oe,
    input wire logic              irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // writes guarded: a mode write may legally move the pin level
    sequence quiet_bus;
        !write && !$past(write) && !$past(write, 2) && !$past(write, 3);
    endsequence
    AST_WAIT_FIRST: assert property (($rose(read) || $rose(write)) |-> waitrequest)
        else $error("request not stalled in its first cycle");
    AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    AST_IDLE_NO_WAIT: assert property (!read && !write |-> !waitrequest)
        else $error("wait raised without a request");
    AST_RD_UPPER: assert property (readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_RD_HOLD: assert property (!(read && waitrequest) |=> $stable(readdata))
        else $error("read data moved outside a read");
    AST_X_IDLE_PIN: assert property (
        quiet_bus and !timer_x_counter_pin_oe
        and !$past(timer_x_counter_pin_oe) |-> $stable(timer_x_counter_pin_out))
        else $error("timer x pin moved outside pulse mode");
    AST_Y_IDLE_PIN: assert property (
        quiet_bus and !timer_y_counter_pin_oe
        and !$past(timer_y_counter_pin_oe) |-> $stable(timer_y_counter_pin_out))
        else $error("timer y pin moved outside pulse mode");
    AST_PULSE_GAP: assert property (
        $changed(timer_x_counter_pin_out)
        && timer_x_counter_pin_oe && !write |=> $stable(timer_x_counter_pin_out))
        else $error("pulse toggles closer than the shortest period");
    AST_IRQ_STICKY: assert property (
        $fell(irq) |-> $past(write) || $past(write, 2) || $past(write, 3))
        else $error("interrupt dropped without software clearing it");
    COV_IRQ: cover property ($rose(irq));
    COV_PULSE: cover property (timer_x_counter_pin_oe && $changed(timer_x_counter_pin_out));
    COV_READ: cover property (read && !waitrequest);
endmodule

bind four_timer_unit four_timer_unit_props #(.SLOW_DIV(SLOW_DIV), .FAST_DIV(FAST_DIV)) props_i (
    .sys_clk(sys_clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .timer_x_counter_pin_in(timer_x_counter_pin_in),
    .timer_x_counter_pin_out(timer_x_counter_pin_out),
    .timer_x_counter_pin_oe(timer_x_counter_pin_oe),
    .timer_y_counter_pin_in(timer_y_counter_pin_in),
    .timer_y_counter_pin_out(timer_y_counter_pin_out),
    .timer_y_counter_pin_oe(timer_y_counter_pin_oe), .irq(irq));

// ### bench/pin_model.sv
`timescale 1ns/1ps
module pin_model (
    input  wire logic sys_clk,
    input  wire logic ext_level,
    input  wire logic dut_out,
    input  wire logic dut_oe,
    output logic      pin,
    output int        toggles
);
    logic last;
    // no pull on the pin: the outside source drives it whenever released
    assign pin = dut_oe ? dut_out : ext_level;
    initial toggles = 0;
    initial last = 1'b1;
    always @(posedge sys_clk) begin
        last <= dut_out;
        if (dut_oe && dut_out !== last) toggles <= toggles + 1;
    end
endmodule

// ### bench/four_timer_unit_tb.sv
`timescale 1ns/1ps
module four_timer_unit_tb;
    import timer_unit_pkg::*;
    localparam int SLOW = 4;
    localparam int FAST = 2;
    logic              sys_clk = 0, resetn = 0, read = 0, write = 0, x_ext = 0, y_ext = 0;
    logic [ADDR_W-1:0] address = '0;
    logic [DATA_W-1:0] writedata = '0, readdata, rd;
    logic [3:0]        byteenable = 4'h1;
    logic              waitrequest, irq, x_in, x_out, x_oe, y_in, y_out, y_oe;
    int                x_tog, y_tog, fail_count = 0, tests_run = 0, seed = 31, p, n;

    four_timer_unit #(.SLOW_DIV(SLOW), .FAST_DIV(FAST)) four_timer_unit_i (
        .sys_clk(sys_clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .timer_x_counter_pin_in(x_in),
        .timer_x_counter_pin_out(x_out), .timer_x_counter_pin_oe(x_oe),
        .timer_y_counter_pin_in(y_in), .timer_y_counter_pin_out(y_out),
        .timer_y_counter_pin_oe(y_oe), .irq(irq));
    pin_model pin_x_i (.sys_clk(sys_clk), .ext_level(x_ext), .dut_out(x_out),
        .dut_oe(x_oe), .pin(x_in), .toggles(x_tog));
    pin_model pin_y_i (.sys_clk(sys_clk), .ext_level(y_ext), .dut_out(y_out),
        .dut_oe(y_oe), .pin(y_in), .toggles(y_tog));

    initial forever #2.5 sys_clk = ~sys_clk;
    // the full run needs about 6000 cycles
    initial begin
        repeat (30000) @(posedge sys_clk);
        fail_count++;
        end_sim();
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    task automatic end_sim;
        $display("tests %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        logic [ADDR_W-1:0] offs [9];
        int e, k, d;
        offs = '{OFF_TIMER1, OFF_TIMER2, OFF_TIMERX, OFF_TIMERY, OFF_MODE, OFF_SOURCE,
                 OFF_IRQ_STATUS, OFF_IRQ_MASK, 6'h2c};
        cyc(8);
        resetn <= 1'b1;
        check("x_out", x_out, 1);
        check("x_oe", x_oe, 0);
        check("irq", irq, 0);
        // prescalers are already running, so only timers, control registers and an unused offset are read back
        for (int i = 0; i < 9; i++) rdc("reset", offs[i], i < 4 ? 32'hff : 32'h0);
        $display("test reset done");
        bus(1, OFF_SOURCE, 32'h4);
        bus(1, OFF_MODE, 32'h88);
        p = $unsigned($random(seed)) % 4;
        bus(1, OFF_PRESCALER12, 32'h0);
        bus(1, OFF_TIMER1, 32'h3);
        bus(1, OFF_TIMER2, 32'h9);
        bus(1, OFF_PRESCALERX, p);
        cyc(1100);
        for (e = 0; e < 2; e++) begin
            n = $unsigned($random(seed)) % 8;
            bus(1, OFF_MODE, 32'h88 | (e << 2));
            bus(1, OFF_TIMERX, n);
            bus(1, OFF_MODE, 32'h89 | (e << 2));
            cyc(2);
            check("x_start", x_out, !e);
            check("x_oe_on", x_oe, 1);
            k = x_tog;
            bus(1, OFF_MODE, 32'h81 | (e << 2));
            cyc(2000);
            d = x_tog - k - 2000 / ((p + 1) * (n + 1) * FAST);
            check("x_rate", d >= -1 && d <= 1, 1);
        end
        $display("test pulse done");
        bus(0, OFF_IRQ_STATUS, 0);
        check("x_status", rd[IRQ_TX_BIT], 1);
        bus(1, OFF_IRQ_MASK, 32'h4);
        // mask lands at the completing edge, irq follows one edge later
        cyc(2);
        check("irq_on", irq, 1);
        bus(1, OFF_MODE, 32'h89);
        bus(1, OFF_IRQ_STATUS, 32'h4);
        cyc(4);
        check("irq_off", irq, 0);
        bus(0, OFF_TIMERX, 0);
        k = rd;
        cyc(50);
        rdc("x_halt", OFF_TIMERX, k);
        bus(1, OFF_IRQ_MASK, 32'h0);
        $display("test stop done");
        for (e = 0; e < 2; e++) begin
            bus(1, OFF_MODE, 32'ha8 | (e << 6));
            y_ext <= 1'b0;
            cyc(6);
            bus(1, OFF_TIMERY, 32'h14);
            bus(1, OFF_MODE, 32'h28 | (e << 6));
            k = 1 + $unsigned($random(seed)) % 6;
            repeat (k) begin
                y_ext <= 1'b1;
                cyc(6);
                y_ext <= 1'b0;
                cyc(6);
            end
            y_ext <= 1'b1;
            cyc(6);
            bus(1, OFF_MODE, 32'ha8 | (e << 6));
            rdc("y_events", OFF_TIMERY, 20 - (e ? k : k + 1));
        end
        $display("test event done");
        for (e = 0; e < 2; e++) begin
            bus(1, OFF_MODE, 32'h8b | (e << 2));
            x_ext <= e;
            bus(1, OFF_TIMERX, 32'hc8);
            bus(1, OFF_MODE, 32'h83 | (e << 2));
            cyc(4);
            x_ext <= !e;
            cyc(40 * (p + 1));
            x_ext <= e;
            cyc(4);
            bus(1, OFF_MODE, 32'h8b | (e << 2));
            bus(0, OFF_TIMERX, 0);
            d = int'(rd) - (200 - 40 / FAST);
            check("x_width", d >= -2 && d <= 2, 1);
        end
        $display("test width done");
        bus(1, OFF_IRQ_STATUS, 32'h3);
        cyc(60);
        bus(0, OFF_IRQ_STATUS, 0);
        check("t12_status", rd[1:0], 2'b11);
        bus(1, OFF_IRQ_MASK, 32'h1);
        cyc(2);
        check("t1_irq", irq, 1);
        $display("test timers12 done");
        end_sim();
    end
endmodule
